/* File: rtl/slot_port_regs.vh */
// Constants for the crossbar slave-side slot port set.
`ifndef SLOT_PORT_REGS_VH
`define SLOT_PORT_REGS_VH
`define SLOTS 2
`define ID_W 4
`define ADDR_W 32
`define DATA_W 32
`define STRB_W 4
`define AWUSER_W 1
`define WUSER_W 1
`define BUSER_W 1
`define ARUSER_W 1
`define LEN_W 8
`define SIZE_W 3
`define BURST_W 2
`define LOCK_W 2
`define CACHE_W 4
`define PROT_W 3
`define QOS_W 4
`define RESP_W 2
`define PROT_DEFAULT 3'h0
`define PROT_NONSECURE_BIT 1
`define LOCK_MAX 2'h1
`define BURST_MAX 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: rtl/slot_reset_sync.v */
// Per-slot active-low reset release synchroniser.
`timescale 1ns/100ps
module slot_reset_sync (
  input wire slot_clk,
  input wire rst_n,
  output wire rst_out_n
);
  // Two-stage chain: asserts at once, releases on the second slot clock edge.
  reg meta_q;
  reg sync_q;

  // The first stage is only read by the second stage.
  always @(posedge slot_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      sync_q <= meta_q;
    end
  end

  assign rst_out_n = sync_q;
endmodule

/* File: rtl/slot_port.v */
// Slave-side slot port set: address, data and response channels per master.
`timescale 1ns/100ps
`include "slot_port_regs.vh"
module slot_port (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [`SLOTS-1:0] slot_clk,
  input wire [`SLOTS-1:0] lite_mode,
  input wire pass_through_axi3,
  output wire [`SLOTS-1:0] slot_reset_out_low,
  input wire [`SLOTS*`ID_W-1:0] awid,
  input wire [`SLOTS*`ADDR_W-1:0] awaddr,
  input wire [`SLOTS*`LEN_W-1:0] awlen,
  input wire [`SLOTS*`SIZE_W-1:0] awsize,
  input wire [`SLOTS*`BURST_W-1:0] awburst,
  input wire [`SLOTS*`LOCK_W-1:0] awlock,
  input wire [`SLOTS*`CACHE_W-1:0] awcache,
  input wire [`SLOTS*`PROT_W-1:0] awprot,
  input wire [`SLOTS*`QOS_W-1:0] awqos,
  input wire [`SLOTS*`AWUSER_W-1:0] awuser,
  input wire [`SLOTS-1:0] awvalid,
  output wire [`SLOTS-1:0] awready,
  input wire [`SLOTS*`ID_W-1:0] wid,
  input wire [`SLOTS*`DATA_W-1:0] wdata,
  input wire [`SLOTS*`STRB_W-1:0] wstrb,
  input wire [`SLOTS-1:0] wlast,
  input wire [`SLOTS*`WUSER_W-1:0] wuser,
  input wire [`SLOTS-1:0] wvalid,
  output wire [`SLOTS-1:0] wready,
  output wire [`SLOTS*`ID_W-1:0] bid,
  output wire [`SLOTS*`RESP_W-1:0] bresp,
  output wire [`SLOTS*`BUSER_W-1:0] buser,
  output wire [`SLOTS-1:0] bvalid,
  input wire [`SLOTS-1:0] bready,
  input wire [`SLOTS*`ID_W-1:0] arid,
  input wire [`SLOTS*`ADDR_W-1:0] araddr,
  input wire [`SLOTS*`LEN_W-1:0] arlen,
  input wire [`SLOTS*`SIZE_W-1:0] arsize,
  input wire [`SLOTS*`BURST_W-1:0] arburst,
  input wire [`SLOTS*`LOCK_W-1:0] arlock,
  input wire [`SLOTS*`CACHE_W-1:0] arcache,
  input wire [`SLOTS*`PROT_W-1:0] arprot,
  input wire [`SLOTS*`QOS_W-1:0] arqos,
  input wire [`SLOTS-1:0] arvalid,
  output wire [`SLOTS-1:0] arready,
  output wire [`SLOTS*`ADDR_W-1:0] fwd_awaddr,
  output wire [`SLOTS*`ID_W-1:0] fwd_awid,
  output wire [`SLOTS*`LEN_W-1:0] fwd_awlen,
  output wire [`SLOTS*`QOS_W-1:0] fwd_awqos,
  output wire [`SLOTS-1:0] fwd_aw_secure,
  output wire [`SLOTS*`ID_W-1:0] fwd_wid,
  output wire [`SLOTS*`DATA_W-1:0] fwd_wdata,
  output wire [`SLOTS*`STRB_W-1:0] fwd_wstrb,
  output wire [`SLOTS*`ADDR_W-1:0] fwd_araddr,
  output wire [`SLOTS*`ID_W-1:0] fwd_arid,
  output wire [`SLOTS*`LEN_W-1:0] fwd_arlen,
  output wire [`SLOTS*`QOS_W-1:0] fwd_arqos,
  output wire [`SLOTS-1:0] fwd_ar_secure
);

  //////////////////////////////////////////////////////////////////////////////
  // Every channel is one generate slice per slot, concatenated by index.
  genvar s;
  generate
    for (s = 0; s < `SLOTS; s = s + 1) begin : g_slot
      // Reset release toward the master on this slot's own clock.
      slot_reset_sync u_rst (
        .slot_clk(slot_clk[s]),
        .rst_n(rst_n),
        .rst_out_n(slot_reset_out_low[s])
      );

      // Lite flag: lite slots ignore lock and zero ID, length and QoS, but still keep the data-channel ID in AXI3 pass-through.
      wire lite = lite_mode[s];
      wire aw_fire = awvalid[s] & awready[s];
      wire w_fire = wvalid[s] & wready[s];
      wire ar_fire = arvalid[s] & arready[s];
      wire b_fire = bvalid[s] & bready[s];

      // On full slots, lock codes above one are refused: an error response on writes, no capture on reads.
      wire aw_lock_bad = ~lite & (awlock[s*`LOCK_W +: `LOCK_W] > `LOCK_MAX);
      wire ar_lock_bad = ~lite & (arlock[s*`LOCK_W +: `LOCK_W] > `LOCK_MAX);
      // Every size code from 0 to 7 is legal, so the size input is never refused.

      // Slot state: one write outstanding, one read address held.
      reg aw_full_q;
      reg w_full_q;
      reg b_full_q;
      reg ar_full_q;
      reg aw_err_q;
      reg [`ID_W-1:0] aw_id_q;
      reg [`ID_W-1:0] b_id_q;
      reg [`RESP_W-1:0] b_resp_q;
      reg [`ADDR_W-1:0] aw_addr_q;
      reg [`LEN_W-1:0] aw_len_q;
      reg [`QOS_W-1:0] aw_qos_q;
      reg aw_sec_q;
      reg [`ID_W-1:0] w_id_q;
      reg [`DATA_W-1:0] w_data_q;
      reg [`STRB_W-1:0] w_strb_q;
      reg [`ADDR_W-1:0] ar_addr_q;
      reg [`ID_W-1:0] ar_id_q;
      reg [`LEN_W-1:0] ar_len_q;
      reg [`QOS_W-1:0] ar_qos_q;
      reg ar_sec_q;

      // Ready is combinational; a slot's write channels stall until its response drains.
      assign awready[s] = ~aw_full_q & ~b_full_q;
      assign wready[s] = aw_full_q & ~w_full_q;
      assign arready[s] = ~ar_full_q;
      assign bvalid[s] = b_full_q;
      assign bid[s*`ID_W +: `ID_W] = b_id_q;
      assign bresp[s*`RESP_W +: `RESP_W] = b_resp_q;
      assign buser[s*`BUSER_W +: `BUSER_W] = {`BUSER_W{1'b0}};

      // Write address, data and response sequencing.
      // The last-beat input is not needed: one beat closes the write,
      // which keeps the slot simple at the cost of bursts.
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          aw_full_q <= 1'b0;
          w_full_q <= 1'b0;
          b_full_q <= 1'b0;
          aw_err_q <= 1'b0;
          aw_id_q <= {`ID_W{1'b0}};
          b_id_q <= {`ID_W{1'b0}};
          b_resp_q <= `RESP_OKAY;
          aw_addr_q <= {`ADDR_W{1'b0}};
          aw_len_q <= {`LEN_W{1'b0}};
          aw_qos_q <= {`QOS_W{1'b0}};
          aw_sec_q <= 1'b0;
          w_id_q <= {`ID_W{1'b0}};
          w_data_q <= {`DATA_W{1'b0}};
          w_strb_q <= {`STRB_W{1'b0}};
        end else if (clk_en) begin
          if (aw_fire) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= awaddr[s*`ADDR_W +: `ADDR_W];
            // Lite slots force ID, length and QoS to zero.
            aw_id_q <= lite ? {`ID_W{1'b0}} : awid[s*`ID_W +: `ID_W];
            aw_len_q <= lite ? {`LEN_W{1'b0}} : awlen[s*`LEN_W +: `LEN_W];
            aw_qos_q <= lite ? {`QOS_W{1'b0}} : awqos[s*`QOS_W +: `QOS_W];
            // Protection bit one clear, including the all-zero default, is secure.
            aw_sec_q <= ~awprot[s*`PROT_W + `PROT_NONSECURE_BIT];
            aw_err_q <= aw_lock_bad;
          end
          if (w_fire) begin
            w_full_q <= 1'b1;
            w_data_q <= wdata[s*`DATA_W +: `DATA_W];
            w_strb_q <= wstrb[s*`STRB_W +: `STRB_W];
            // The data-channel ID is only kept in AXI3 pass-through.
            w_id_q <= pass_through_axi3 ? wid[s*`ID_W +: `ID_W] : {`ID_W{1'b0}};
          end
          if (aw_full_q && w_full_q) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            b_full_q <= 1'b1;
            b_id_q <= aw_id_q;
            b_resp_q <= aw_err_q ? `RESP_SLVERR : `RESP_OKAY;
          end else if (b_fire) begin
            b_full_q <= 1'b0;
          end
        end
      end

      // Read address holding stage, released one cycle after capture.
      // A refused lock code leaves the held read fields untouched, so the
      // crossbar core never sees an address that was not accepted.
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ar_full_q <= 1'b0;
          ar_addr_q <= {`ADDR_W{1'b0}};
          ar_id_q <= {`ID_W{1'b0}};
          ar_len_q <= {`LEN_W{1'b0}};
          ar_qos_q <= {`QOS_W{1'b0}};
          ar_sec_q <= 1'b0;
        end else if (clk_en) begin
          if (ar_fire && !ar_lock_bad) begin
            ar_full_q <= 1'b1;
            ar_addr_q <= araddr[s*`ADDR_W +: `ADDR_W];
            ar_id_q <= lite ? {`ID_W{1'b0}} : arid[s*`ID_W +: `ID_W];
            ar_len_q <= lite ? {`LEN_W{1'b0}} : arlen[s*`LEN_W +: `LEN_W];
            ar_qos_q <= lite ? {`QOS_W{1'b0}} : arqos[s*`QOS_W +: `QOS_W];
            ar_sec_q <= ~arprot[s*`PROT_W + `PROT_NONSECURE_BIT];
          end else begin
            ar_full_q <= 1'b0;
          end
        end
      end

      // Captured fields toward the crossbar core.
      assign fwd_awaddr[s*`ADDR_W +: `ADDR_W] = aw_addr_q;
      assign fwd_awid[s*`ID_W +: `ID_W] = aw_id_q;
      assign fwd_awlen[s*`LEN_W +: `LEN_W] = aw_len_q;
      assign fwd_awqos[s*`QOS_W +: `QOS_W] = aw_qos_q;
      assign fwd_aw_secure[s] = aw_sec_q;
      assign fwd_wid[s*`ID_W +: `ID_W] = w_id_q;
      assign fwd_wdata[s*`DATA_W +: `DATA_W] = w_data_q;
      assign fwd_wstrb[s*`STRB_W +: `STRB_W] = w_strb_q;
      assign fwd_araddr[s*`ADDR_W +: `ADDR_W] = ar_addr_q;
      assign fwd_arid[s*`ID_W +: `ID_W] = ar_id_q;
      assign fwd_arlen[s*`LEN_W +: `LEN_W] = ar_len_q;
      assign fwd_arqos[s*`QOS_W +: `QOS_W] = ar_qos_q;
      assign fwd_ar_secure[s] = ar_sec_q;
    end
  endgenerate

endmodule

/* File: testbench/slot_port_checker.sv */
// Checker of slot 0 handshakes and captures of the slot port.
`timescale 1ns/100ps
module slot_port_checker (
  input wire sys_clk, rst_n, clk_en,
  input wire [1:0] lite_mode, awvalid, awready, wvalid, wready, bvalid, bready,
  input wire [1:0] arvalid, arready, fwd_aw_secure,
  input wire [3:0] awlock, arlock, bresp,
  input wire [5:0] awprot,
  input wire [7:0] fwd_awid, bid,
  input wire [15:0] awlen, fwd_awlen
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Accepts with a legal lock code; on a full slot only such reads are forwarded, writes always are.
  wire aw_ok = awvalid[0] & awready[0] & clk_en & (lite_mode[0] | ~awlock[1]);
  wire ar_ok = arvalid[0] & arready[0] & clk_en & (lite_mode[0] | ~arlock[1]);
  b_hold_a: assert property (bvalid[0] & !bready[0] |=> bvalid[0] && $stable(bid[3:0]))
    else $error("response dropped while stalled");
  b_code_a: assert property (bvalid[0] |-> bresp[1:0] inside {2'h0, 2'h2})
    else $error("bad response code");
  b_time_a: assert property (wvalid[0] & wready[0] & clk_en |-> ##2 bvalid[0])
    else $error("response late");
  aw_stop_a: assert property (bvalid[0] |-> !awready[0])
    else $error("address open while response pending");
  w_gate_a: assert property ($rose(wready[0]) |-> $past(awvalid[0] & awready[0]))
    else $error("data ready before address");
  ar_gap_a: assert property (ar_ok |=> !arready[0])
    else $error("read ready not dropped");
  secure_a: assert property (aw_ok |=> fwd_aw_secure[0] == !$past(awprot[1]))
    else $error("secure flag wrong");
  lite_zero_a: assert property (aw_ok && lite_mode[0] |=> fwd_awid[3:0] == 4'h0)
    else $error("lite id not zero");
  len_pass_a: assert property (aw_ok && !lite_mode[0] |=>
    fwd_awlen[7:0] == $past(awlen[7:0])) else $error("length wrong");
endmodule
bind slot_port slot_port_checker chk_u (.*);

/* File: testbench/slot_master_model.sv */
// Behavioural bus master that drives every slave-side slot.
`timescale 1ns/100ps
module slot_master_model (
  input wire sys_clk,
  input wire [1:0] awready, wready, bvalid, arready,
  input wire [3:0] bresp,
  input wire [7:0] bid,
  output logic [1:0] awuser, wuser, wlast, awvalid, wvalid, bready, arvalid,
  output logic [3:0] awburst, arburst, awlock, arlock,
  output logic [5:0] awsize, arsize, awprot, arprot,
  output logic [7:0] awid, wid, arid, wstrb, awcache, arcache, awqos, arqos,
  output logic [15:0] awlen, arlen,
  output logic [63:0] awaddr, araddr, wdata
);
  // Idle values: word size and incrementing bursts are always driven.
  initial begin
    {awuser, wuser, wlast, awvalid, wvalid, bready, arvalid} = 14'h0;
    {awlock, arlock, awprot, arprot, awid, wid, arid, awcache, arcache} = 60'h0;
    {awqos, arqos, awlen, arlen, awaddr, araddr, wdata, wstrb} = 248'h0;
    {awsize, arsize, awburst, arburst} = {12'h492, 8'h55};
  end
  // One write; each request is held until ready is seen at a rising edge.
  task wr(input int s, input logic [3:0] id, input logic [7:0] ln, input logic [1:0] lk,
    input logic [2:0] pr, input logic [31:0] d, input logic [3:0] st, input int dly,
    output logic [3:0] rid, output logic [1:0] rr);
    @(negedge sys_clk);
    {awid[s*4+:4], awlen[s*8+:8], awlock[s*2+:2], awprot[s*3+:3], awaddr[s*32+:32],
      awqos[s*4+:4]} = {id, ln, lk, pr, d, ln[3:0]};
    awvalid[s] = 1'b1;
    do @(posedge sys_clk); while (!awready[s]);
    @(negedge sys_clk);
    awvalid[s] = 1'b0;
    awaddr[s*32+:32] = ~d;
    {wid[s*4+:4], wdata[s*32+:32], wstrb[s*4+:4]} = {id, d, st};
    wvalid[s] = 1'b1;
    do @(posedge sys_clk); while (!wready[s]);
    @(negedge sys_clk);
    wvalid[s] = 1'b0;
    wdata[s*32+:32] = ~d;
    // A slow master stalls the response for a few cycles.
    repeat (dly) @(negedge sys_clk);
    bready[s] = 1'b1;
    do @(posedge sys_clk); while (!bvalid[s]);
    {rid, rr} = {bid[s*4+:4], bresp[s*2+:2]};
    @(negedge sys_clk);
    bready[s] = 1'b0;
  endtask
  // One read address transfer.
  task rd(input int s, input logic [3:0] id, input logic [1:0] lk, input logic [31:0] a);
    @(negedge sys_clk);
    {arid[s*4+:4], arlock[s*2+:2], araddr[s*32+:32], arqos[s*4+:4], arprot[s*3+:3]} =
      {id, lk, a, id, a[2:0]};
    arvalid[s] = 1'b1;
    do @(posedge sys_clk); while (!arready[s]);
    @(negedge sys_clk);
    arvalid[s] = 1'b0;
    araddr[s*32+:32] = ~a;
  endtask
endmodule

/* File: testbench/slot_port_tb_top.sv */
// Self-checking bench for the slave-side slot port.
`timescale 1ns/100ps
`include "slot_port_regs.vh"
module slot_port_tb_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, pass_through_axi3 = 1'b0;
  logic [1:0] slot_clk = 2'h0, lite_mode = 2'h0;
  wire [1:0] awready, wready, bvalid, arready, buser, fwd_aw_secure, fwd_ar_secure;
  wire [1:0] slot_reset_out_low, awuser, wuser, wlast, awvalid, wvalid, bready, arvalid;
  wire [3:0] awburst, arburst, awlock, arlock, bresp;
  wire [5:0] awsize, arsize, awprot, arprot;
  wire [7:0] awid, wid, arid, wstrb, awcache, arcache, awqos, arqos, bid, fwd_awid;
  wire [7:0] fwd_awqos, fwd_wid, fwd_wstrb, fwd_arid, fwd_arqos;
  wire [15:0] awlen, arlen, fwd_awlen, fwd_arlen;
  wire [63:0] awaddr, araddr, wdata, fwd_awaddr, fwd_wdata, fwd_araddr;
  int seed = 32'hdb65, n_mismatch = 0, checks = 0, s;
  logic [16:0] pad;
  logic [31:0] d, a, old;
  logic [7:0] ln;
  logic [3:0] id, rid, st;
  logic [2:0] pr;
  logic [1:0] lk, rr;
  bit lt, fw;
  slot_port dut_u (.*);
  slot_master_model m_u (.*);
  // Slot clocks are unrelated to the system clock.
  initial forever #12.5 sys_clk = ~sys_clk;
  initial forever #17 slot_clk[0] = ~slot_clk[0];
  initial forever #23 slot_clk[1] = ~slot_clk[1];
  // Lock codes above one are refused on a full slot only.
  function logic [1:0] exp_resp(input bit lt, input logic [1:0] lk);
    exp_resp = (!lt && lk > `LOCK_MAX) ? `RESP_SLVERR : `RESP_OKAY;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Every lock code on both slots, in lite and full mode, with random fields.
  initial begin
    repeat (12) @(negedge sys_clk);
    chk("reset_out", 2'h0, slot_reset_out_low);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk("reset_out", 2'h3, slot_reset_out_low);
    for (int i = 0; i < 32; i++) begin
      s = i % 2;
      lt = (i % 8) > 5;
      lk = i[4:3];
      fw = lt || !lk[1];
      lite_mode[s] = lt;
      pass_through_axi3 = i[2];
      {pad, id, ln, pr, d, a} = {$random(seed), $random(seed), $random(seed)};
      st = (i < 2) ? 4'hf : d[7:4];
      m_u.wr(s, id, ln, lk, pr, d, st, i % 3, rid, rr);
      chk("bresp", exp_resp(lt, lk), rr);
      chk("bid", lt ? 4'h0 : id, rid);
      chk("wdata", d, fwd_wdata[s*32+:32]);
      chk("wstrb", st, fwd_wstrb[s*4+:4]);
      if (!lt) chk("wid", pass_through_axi3 ? id : 4'h0, fwd_wid[s*4+:4]);
      chk("awaddr", d, fwd_awaddr[s*32+:32]);
      if (fw) begin
        chk("awlen", lt ? 8'h0 : ln, fwd_awlen[s*8+:8]);
        chk("awqos", lt ? 4'h0 : ln[3:0], fwd_awqos[s*4+:4]);
        chk("secure", !pr[1], fwd_aw_secure[s]);
      end
      old = fwd_araddr[s*32+:32];
      m_u.rd(s, id, lk, a);
      chk("araddr", fw ? a : old, fwd_araddr[s*32+:32]);
      if (fw) chk("arid", lt ? 4'h0 : id, fwd_arid[s*4+:4]);
      if (fw) chk("arqos", lt ? 4'h0 : id, fwd_arqos[s*4+:4]);
      if (fw) chk("ar_secure", !a[1], fwd_ar_secure[s]);
    end
    chk("buser", 2'h0, buser);
    // With the enable low, a read handshake must leave the held read address alone.
    clk_en = 1'b0;
    old = fwd_araddr[31:0];
    m_u.rd(0, 4'h1, 2'h0, ~old);
    chk("frozen", old, fwd_araddr[31:0]);
    clk_en = 1'b1;
    // A second reset in mid-run pulls the slot resets low at once.
    rst_n = 1'b0;
    #1;
    chk("reset_out", 2'h0, slot_reset_out_low);
    chk("bvalid", 2'h0, bvalid);
    chk("wdata", 32'h0, fwd_wdata[31:0]);
    // Hold the reset over two edges, release it and run one more write.
    lite_mode = 2'h0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk("reset_out", 2'h3, slot_reset_out_low);
    m_u.wr(1, 4'h5, 8'h0, 2'h0, 3'h2, 32'h1234_5678, 4'hf, 0, rid, rr);
    chk("bid", 4'h5, rid);
    chk("bresp", `RESP_OKAY, rr);
    summarize();
  end
  // Watchdog: the run needs about 7 us.
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule
